// File: design/sadc_pkg.sv
// shared constants and types for the scanning converter sequencer
package sadc_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned NUM_CHANNELS    = 8;
  localparam int unsigned CHAN_W          = 3;
  localparam int unsigned DATA_W          = 8;

  // conversion frame, in converter clock periods
  localparam int unsigned CONV_PERIODS    = 80;
  localparam int unsigned SCAN_PERIODS    = 640;
  localparam int unsigned MARK_SHORT      = 8;
  localparam int unsigned MARK_EXTRA      = 64;
  localparam int unsigned MARK_LONG       = 72;
  localparam int unsigned WRITE_LEAD      = 6;
  localparam int unsigned START_DELAY     = 8;
  localparam int unsigned STARTUP_MAX     = 800;

  // memory write completion bound
  localparam int unsigned WRITE_DONE_NS   = 200;
  localparam int unsigned WRITE_DONE_CYC  =
    (WRITE_DONE_NS / CLK_PERIOD_NS) < 1 ? 1 : (WRITE_DONE_NS / CLK_PERIOD_NS);

  // frame positions within one 80-period channel slot
  localparam logic [6:0] POS_START     = 7'h00;
  localparam logic [6:0] POS_SAR_LAST  = 7'h07;
  localparam logic [6:0] POS_MARK      = 7'(CONV_PERIODS - START_DELAY);
  localparam logic [6:0] POS_WRITE     = 7'(CONV_PERIODS - START_DELAY - WRITE_LEAD);
  localparam logic [6:0] POS_LAST      = 7'(CONV_PERIODS - 1);

  localparam logic [2:0] IDENT_CHANNEL = 3'h0;
  localparam logic [2:0] CHAN_RESET    = 3'h7;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic [9:0] STARTUP_CYC   = 10'(STARTUP_MAX - 1);
  localparam logic [6:0] MARK_SHORT_C  = 7'(MARK_SHORT);
  localparam logic [6:0] MARK_LONG_C   = 7'(MARK_LONG);

  typedef enum logic [1:0] {
    SADC_ST_STARTUP,
    SADC_ST_SCAN
  } sadc_state_t;

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [DATA_W-1:0] data;
  } sadc_wr_t;

endpackage

// File: design/sadc_sar.sv
// successive approximation register, msb first
`timescale 1ns/100ps
module sadc_sar
  import sadc_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // control
  input  wire logic              start_i,
  input  wire logic              step_i,
  input  wire logic              comp_high_i,
  // result
  output logic [DATA_W-1:0]      trial_o,
  output logic [DATA_W-1:0]      result_o
);

  logic [DATA_W-1:0] trial_reg;
  logic [DATA_W-1:0] trial_next;
  logic [DATA_W-1:0] bit_reg;
  logic [DATA_W-1:0] bit_next;
  logic [DATA_W-1:0] kept;
  logic [DATA_W-1:0] done_value;

  // drop the trial bit when the dac exceeds the input
  assign kept       = comp_high_i ? (trial_reg & ~bit_reg) : trial_reg;
  assign done_value = kept;
  assign bit_next   = start_i ? 8'h80 : (step_i ? (bit_reg >> 1) : bit_reg);
  assign trial_next = start_i ? 8'h80
                    : (step_i ? (kept | (bit_reg >> 1)) : trial_reg);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      trial_reg <= DATA_RESET;
      bit_reg   <= DATA_RESET;
      result_o  <= DATA_RESET;
    end else begin
      trial_reg <= trial_next;
      bit_reg   <= bit_next;
      if (step_i && bit_reg == 8'h01) begin
        result_o <= done_value;
      end
    end
  end

  assign trial_o = trial_reg;

endmodule

// File: design/sadc_core.sv
// scanning converter sequencer with result memory and read port
`timescale 1ns/100ps
//
// Overview of operation
// - the address latch is transparent while the strobe is high and holds when it falls.
// - the latched address, top input as msb, picks which of channels 0..7 is read.
// - with chip select high all eight result outputs are released.
// - with chip select low the outputs drive the addressed channel's result.
// - an ordinary conversion ends with the marker low for exactly 8 periods.
// - the identifying channel stretches the marker by 64 to 72 periods in total.
// - a result is written into its channel location on the rising edge at POS_WRITE, or once chip select rises if a read defers it; no 200 ns bound applies.
// - the memory write falls 6 periods before the marker goes low.
// - each channel takes 80 periods, a whole scan 640.
// - the channel address decrements as the marker falls; conversion restarts 8 later.
// - start-up logic settles the sequence within 800 periods before scanning.
// - memory writes are placed only when the processor is not reading.
module sadc_core
  import sadc_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // analog front end
  input  wire logic              comp_high_i,
  output logic [DATA_W-1:0]      dac_code_o,
  output logic [CHAN_W-1:0]      mux_channel_o,
  // processor read port
  input  wire logic [CHAN_W-1:0] channel_address_i,
  input  wire logic              addr_strobe_i,
  input  wire logic              chip_select_n_i,
  output logic [DATA_W-1:0]      result_bus_o,
  output logic [DATA_W-1:0]      result_bus_oe_n_o,
  // status
  output logic                   conv_mark_n_o,
  output logic                   scanning_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [CHAN_W-1:0] addr_s1_reg;
  logic [CHAN_W-1:0] addr_s2_reg;
  logic              stb_s1_reg;
  logic              stb_s2_reg;
  logic              cs_s1_n_reg;
  logic              cs_s2_n_reg;
  logic              comp_s1_reg;
  logic              comp_s2_reg;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      addr_s1_reg <= '0;
      addr_s2_reg <= '0;
      stb_s1_reg  <= 1'b0;
      stb_s2_reg  <= 1'b0;
      cs_s1_n_reg <= 1'b1;
      cs_s2_n_reg <= 1'b1;
      comp_s1_reg <= 1'b0;
      comp_s2_reg <= 1'b0;
    end else begin
      addr_s1_reg <= channel_address_i;
      addr_s2_reg <= addr_s1_reg;
      stb_s1_reg  <= addr_strobe_i;
      stb_s2_reg  <= stb_s1_reg;
      cs_s1_n_reg <= chip_select_n_i;
      cs_s2_n_reg <= cs_s1_n_reg;
      comp_s1_reg <= comp_high_i;
      comp_s2_reg <= comp_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // address latch
  logic [CHAN_W-1:0] addr_latch_reg;
  logic [CHAN_W-1:0] read_addr;

  // transparent while strobe high
  assign read_addr = stb_s2_reg ? addr_s2_reg : addr_latch_reg;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      addr_latch_reg <= '0;
    end else begin
      addr_latch_reg <= read_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer
  sadc_state_t       state_reg;
  sadc_state_t       state_next;
  logic [9:0]        boot_cnt_reg;
  logic [6:0]        pos_reg;
  logic [6:0]        pos_next;
  logic [CHAN_W-1:0] chan_reg;
  logic [6:0]        mark_cnt_reg;
  logic              scan;
  logic              at_last;
  logic              at_write;
  logic              at_mark;
  logic              sar_start;
  logic              sar_step;
  logic [6:0]        mark_len;

  assign scan      = (state_reg == SADC_ST_SCAN);
  assign at_last   = scan && (pos_reg == POS_LAST);
  assign at_write  = scan && (pos_reg == POS_WRITE);
  assign at_mark   = scan && (pos_reg == POS_MARK);
  // conversion restarts eight periods after the marker falls
  assign sar_start = scan && (pos_reg == POS_START);
  assign sar_step  = scan && (pos_reg > POS_START) && (pos_reg <= 7'(POS_SAR_LAST + 7'h01));
  assign pos_next  = at_last ? POS_START : 7'(pos_reg + 7'h01);
  assign mark_len  = (chan_reg == IDENT_CHANNEL) ? MARK_LONG_C : MARK_SHORT_C;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SADC_ST_STARTUP: begin
        if (boot_cnt_reg == STARTUP_CYC) begin
          state_next = SADC_ST_SCAN;
        end
      end
      SADC_ST_SCAN:    state_next = SADC_ST_SCAN;
      default:         state_next = SADC_ST_STARTUP;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_reg    <= SADC_ST_STARTUP;
      boot_cnt_reg <= '0;
      pos_reg      <= POS_START;
      chan_reg     <= CHAN_RESET;
      mark_cnt_reg <= '0;
    end else begin
      state_reg    <= state_next;
      boot_cnt_reg <= scan ? boot_cnt_reg : 10'(boot_cnt_reg + 10'h001);
      pos_reg      <= scan ? pos_next : POS_START;
      if (at_mark) begin
        chan_reg     <= chan_reg - 3'h1;
        mark_cnt_reg <= mark_len;
      end else if (mark_cnt_reg != 7'h00) begin
        mark_cnt_reg <= mark_cnt_reg - 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // converter
  logic [DATA_W-1:0] sar_result;

  sadc_sar u_sar (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .start_i     (sar_start),
    .step_i      (sar_step),
    .comp_high_i (comp_s2_reg),
    .trial_o     (dac_code_o),
    .result_o    (sar_result)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // result memory
  logic [DATA_W-1:0] mem_reg [NUM_CHANNELS];
  sadc_wr_t          pend_reg;
  logic              pend_valid_reg;
  logic              cpu_reading;
  logic              do_write;
  sadc_wr_t          wr_now;
  sadc_wr_t          wr_sel;
  logic [DATA_W-1:0] bus_reg;
  logic [DATA_W-1:0] oe_n_reg;

  assign cpu_reading = !cs_s2_n_reg;
  assign wr_now      = '{chan: chan_reg, data: sar_result};
  // an older deferred result goes first, the fresh one waits a cycle
  assign wr_sel      = pend_valid_reg ? pend_reg : wr_now;
  // write only while the processor is not addressing the memory
  assign do_write    = (pend_valid_reg || at_write) && !cpu_reading;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pend_reg       <= '0;
      pend_valid_reg <= 1'b0;
    end else if (at_write) begin
      pend_reg       <= wr_now;
      pend_valid_reg <= cpu_reading || pend_valid_reg;
    end else if (do_write) begin
      pend_valid_reg <= 1'b0;
    end
  end

  generate
    for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_mem
      always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
          mem_reg[i] <= DATA_RESET;
        end else if (do_write && wr_sel.chan == CHAN_W'(i)) begin
          mem_reg[i] <= wr_sel.data;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // read port
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      bus_reg  <= DATA_RESET;
      oe_n_reg <= 8'hFF;
    end else begin
      bus_reg  <= mem_reg[read_addr];
      oe_n_reg <= {DATA_W{cs_s2_n_reg}};
    end
  end

  assign result_bus_o      = bus_reg;
  assign result_bus_oe_n_o = oe_n_reg;
  assign conv_mark_n_o     = (mark_cnt_reg == 7'h00);
  assign mux_channel_o     = chan_reg;
  assign scanning_o        = scan;

endmodule

// File: dv/sadc_core_assertions.sv
// checker for the sequencer ports
`timescale 1ns/100ps
module sadc_core_checker
  import sadc_pkg::*;
(
  // clock and reset
  input wire logic              clk_i,
  input wire logic              reset_n_i,
  // read port
  input wire logic              chip_select_n_i,
  input wire logic [DATA_W-1:0] result_bus_oe_n_o,
  // status
  input wire logic [CHAN_W-1:0] mux_channel_o,
  input wire logic              conv_mark_n_o,
  input wire logic              scanning_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [6:0] low_reg;
  logic [6:0] per_reg;
  logic [9:0] up_reg;
  logic       seen_reg;
  logic       id_reg;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      low_reg  <= 7'h00;
      per_reg  <= 7'h00;
      up_reg   <= 10'h000;
      seen_reg <= 1'b0;
      id_reg   <= 1'b0;
    end else begin
      low_reg  <= conv_mark_n_o ? 7'h00 : low_reg + 7'h01;
      per_reg  <= (low_reg == 7'h00 && !conv_mark_n_o) ? 7'h01 : per_reg + 7'h01;
      up_reg   <= (up_reg == 10'h3FF) ? up_reg : up_reg + 10'h001;
      seen_reg <= seen_reg | !conv_mark_n_o;
      id_reg   <= (low_reg == 7'h00 && !conv_mark_n_o) ? (mux_channel_o == 3'h7) : id_reg;
    end
  end
  ////////////////////////////////////////////////////////////////
  AST_FLOAT: assert property (chip_select_n_i[*4] |-> &result_bus_oe_n_o)
    else $error("bus driven while deselected");
  AST_DRIVE: assert property ((!chip_select_n_i)[*4] |-> result_bus_oe_n_o == 8'h00)
    else $error("bus not driven while selected");
  AST_MARK_SHORT: assert property ($rose(conv_mark_n_o) && !id_reg |-> low_reg == 7'h08)
    else $error("short marker width wrong");
  AST_MARK_LONG: assert property ($rose(conv_mark_n_o) && id_reg |-> low_reg == 7'h48)
    else $error("long marker width wrong");
  AST_SLOT: assert property ($fell(conv_mark_n_o) && seen_reg |-> per_reg == 7'h50)
    else $error("channel slot length wrong");
  AST_DECR: assert property ($fell(conv_mark_n_o) |->
    mux_channel_o == 3'($past(mux_channel_o) - 3'h1))
    else $error("channel not decremented at marker");
  AST_HOLD: assert property (!$fell(conv_mark_n_o) |-> $stable(mux_channel_o))
    else $error("channel moved outside marker fall");
  AST_STARTUP: assert property (up_reg > 10'h330 |-> scanning_o)
    else $error("start-up too long");
  AST_QUIET: assert property (!scanning_o |-> conv_mark_n_o)
    else $error("marker during start-up");
  C_LONG: cover property ($rose(conv_mark_n_o) && id_reg);
  C_READ: cover property (result_bus_oe_n_o == 8'h00);
  C_SCAN: cover property ($rose(scanning_o));
endmodule
bind sadc_core sadc_core_checker u_sadc_core_checker (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .chip_select_n_i(chip_select_n_i),
  .result_bus_oe_n_o(result_bus_oe_n_o), .mux_channel_o(mux_channel_o),
  .conv_mark_n_o(conv_mark_n_o), .scanning_o(scanning_o));

// File: dv/sadc_cpu_model.sv
// processor model: reads results and times the marker
`timescale 1ns/100ps
module sadc_cpu_model
  import sadc_pkg::*;
(
  // clock
  input wire logic               clk_i,
  // read port
  output logic [CHAN_W-1:0]      channel_address_o,
  output logic                   addr_strobe_o,
  output logic                   chip_select_n_o,
  input wire logic [DATA_W-1:0]  result_bus_i,
  input wire logic [DATA_W-1:0]  result_bus_oe_n_i,
  // status
  input wire logic               conv_mark_n_i
);
  logic [6:0] low_reg = 7'h00;
  logic [6:0] last_len = 7'h00;
  int         ident_cnt = 0;
  logic [DATA_W-1:0] bus_seen;
  // released bits read back inverted, so an undriven bus never matches
  assign bus_seen = result_bus_i ^ result_bus_oe_n_i;
  initial begin
    channel_address_o = 3'h0;
    addr_strobe_o = 1'b0;
    chip_select_n_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (!conv_mark_n_i) begin
      low_reg <= low_reg + 7'h01;
    end else begin
      if (low_reg != 7'h00) last_len <= low_reg;
      if (low_reg == 7'h48) ident_cnt <= ident_cnt + 1;
      low_reg <= 7'h00;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic rd(input logic [2:0] ch, input logic swap, output logic [7:0] d,
                    output logic fl);
    int n;
    @(negedge clk_i);
    channel_address_o = ch;
    addr_strobe_o = 1'b1;
    repeat (4) @(negedge clk_i);
    addr_strobe_o = 1'b0;
    @(negedge clk_i);
    if (swap) channel_address_o = ~ch;
    repeat (2) @(negedge clk_i);
    chip_select_n_o = 1'b0;
    for (n = 0; n < 8 && result_bus_oe_n_i !== 8'h00; n++) @(negedge clk_i);
    @(negedge clk_i);
    d = bus_seen;
    chip_select_n_o = 1'b1;
    repeat (5) @(negedge clk_i);
    fl = (result_bus_oe_n_i === 8'hFF);
  endtask
endmodule

// File: dv/scanning_adc_sequencer_read_port_test.sv
// self-checking bench for the scanning sequencer
`timescale 1ns/100ps
module scanning_adc_sequencer_read_port_test
  import sadc_pkg::*;
;
  logic       clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       comp_high_i = 1'b0;
  logic       inv = 1'b0;
  logic [7:0] dac, rb, oe_n, d;
  logic [2:0] mux, addr;
  logic       strobe, cs_n, mark, scan, fl;
  int         err_count = 0;
  int         checked = 0;
  int         cyc = 0;
  int         n;
  always #5 clk_i = ~clk_i;
  // odd channels convert to zero, even to full scale; inv swaps them
  always @(negedge clk_i) comp_high_i <= mux[0] ^ inv;
  sadc_core u_sadc_core (.clk_i(clk_i), .reset_n_i(reset_n_i), .comp_high_i(comp_high_i),
    .dac_code_o(dac), .mux_channel_o(mux), .channel_address_i(addr),
    .addr_strobe_i(strobe), .chip_select_n_i(cs_n), .result_bus_o(rb),
    .result_bus_oe_n_o(oe_n), .conv_mark_n_o(mark), .scanning_o(scan));
  sadc_cpu_model u_sadc_cpu_model (.clk_i(clk_i), .channel_address_o(addr),
    .addr_strobe_o(strobe), .chip_select_n_o(cs_n), .result_bus_i(rb),
    .result_bus_oe_n_i(oe_n), .conv_mark_n_i(mark));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wmark(input logic v);
    for (n = 0; n < 200 && mark !== v; n++) @(negedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(oe_n, 8'hFF);
    chk(mark, 1'b1);
    chk(mux, 3'h7);
    $display("reset test done");
  endtask
  task automatic t_early;
    u_sadc_cpu_model.rd(3'h3, 1'b0, d, fl);
    chk(d, 8'h00);
    chk(fl, 1'b1);
    for (n = 0; n < 900 && scan !== 1'b1; n++) @(negedge clk_i);
    chk(scan, 1'b1);
    $display("start-up test done");
  endtask
  task automatic t_marker;
    logic [2:0] p;
    p = mux;
    repeat (8) begin
      wmark(1'b0);
      chk(mux, 3'(p - 3'h1));
      p = mux;
      wmark(1'b1);
      @(negedge clk_i);
      chk(u_sadc_cpu_model.last_len, (p == 3'h7) ? 7'h48 : 7'h08);
    end
    chk(u_sadc_cpu_model.ident_cnt, 1);
    $display("marker test done");
  endtask
  task automatic t_read;
    repeat (80) @(negedge clk_i);
    for (int c = 0; c < 8; c++) begin
      u_sadc_cpu_model.rd(3'(c), 1'b0, d, fl);
      chk(d, c[0] ? 8'h00 : 8'hFF);
      chk(fl, 1'b1);
    end
    $display("read test done");
  endtask
  task automatic t_latch;
    u_sadc_cpu_model.rd(3'h5, 1'b1, d, fl);
    chk(d, 8'h00);
    u_sadc_cpu_model.rd(3'h2, 1'b1, d, fl);
    chk(d, 8'hFF);
    $display("latch test done");
  endtask
  // latched address is 2 here; rb follows memory one edge late
  task automatic t_update;
    wmark(1'b1);
    wmark(1'b0);
    inv = 1'b1;
    repeat (8) @(negedge clk_i);
    chk(dac, 8'h80);
    repeat (8) @(negedge clk_i);
    chk(dac, mux[0] ? 8'hFF : 8'h00);
    for (n = 0; n < 700 && rb === 8'hFF; n++) @(negedge clk_i);
    chk(rb, 8'h00);
    for (n = 0; n < 20 && mark !== 1'b0; n++) @(negedge clk_i);
    chk(n, WRITE_LEAD - 1);
    $display("update test done");
  endtask
  initial begin
    repeat (2) @(negedge clk_i);
    t_reset();
    reset_n_i = 1'b1;
    t_early();
    t_marker();
    t_read();
    t_latch();
    t_update();
    close_out();
  end
endmodule
